//--- common/servo_resp_pkg.sv
package servo_resp_pkg;

  // Bus geometry
  localparam int          APB_AW          = 12;
  localparam int          APB_DW          = 32;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL        = 12'h000;
  localparam logic [11:0] OFF_FLAGS       = 12'h004;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h00c;
  localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h010;
  localparam logic [11:0] OFF_WARN_CLEAR  = 12'h014;

  // Control and warning clear register fields
  localparam int          CTRL_HOLD_BIT   = 0;
  localparam int          CTRL_WLATCH_BIT = 1;
  localparam int          CTRL_TQSEL_BIT  = 2;
  localparam int          WCLR_BIT        = 0;

  // Flags register layout
  localparam int          FLG_STATUS_LSB  = 0;
  localparam int          FLG_HEADER_LSB  = 8;
  localparam int          FLG_NODE_LSB    = 16;

  // Response header layout, byte 0
  localparam int          HDR_MARKER_BIT  = 7;
  localparam int          ECHO_LSB        = 5;
  localparam int          ECHO_W          = 2;
  localparam int          NODE_W          = 5;
  localparam logic        RESP_MARKER     = 1'b1;

  // Response status layout, byte 2
  localparam int          ST_ENERGIZED    = 7;
  localparam int          ST_ARMABLE      = 6;
  localparam int          ST_ALARM        = 5;
  localparam int          ST_WARNING      = 4;
  localparam int          ST_TORQUE_CLAMP = 3;
  localparam int          ST_HOME_FOUND   = 2;
  localparam int          ST_MOTION_MAINS = 1;
  localparam int          ST_TARGET_REACH = 0;

  // Interrupt sources
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_ALARM       = 0;
  localparam int          IRQ_WARN        = 1;
  localparam int          IRQ_HOME        = 2;
  localparam int          IRQ_FRAME       = 3;

  // Reset values
  localparam logic [7:0]  HDR_RESET       = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

endpackage : servo_resp_pkg

//--- logic/resp_byte_builder.sv
`timescale 1ns/1ps
module resp_byte_builder
  import servo_resp_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Frame request
  input  wire logic              frame_tick,
  input  wire logic [ECHO_W-1:0] update_count,
  input  wire logic [NODE_W-1:0] node_address_field,
  input  wire logic [7:0]        status_flags,
  // Response bytes
  output logic      [7:0]        resp_header,
  output logic      [7:0]        resp_status,
  output logic                   resp_valid
);

  typedef struct packed {
    logic [7:0] header;
    logic [7:0] status;
    logic       valid;
  } build_t;

  build_t s_q;
  build_t s_d;

  // Next response image, taken once per communication cycle
  always_comb begin
    s_d       = s_q;
    s_d.valid = frame_tick;
    if (frame_tick) begin
      // R1: header byte layout
      s_d.header[HDR_MARKER_BIT]             = RESP_MARKER;  // R2: response marker
      // R3: counter echo copied
      s_d.header[ECHO_LSB +: ECHO_W]         = update_count;
      s_d.header[NODE_W-1:0]                 = node_address_field;
      // R17: refreshed every frame
      s_d.status                             = status_flags;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{header: HDR_RESET, status: STATUS_RESET, valid: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign resp_header = s_q.header;
  assign resp_status = s_q.status;
  assign resp_valid  = s_q.valid;

endmodule : resp_byte_builder

//--- logic/servo_resp_framer.sv
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Contract
// R1: Header byte 0: marker bit 7, counter echo middle, node address low five bits.
// R2: Marker bit is always 1 in every response frame.
// R3: Counter echo field copies the master update counter of the command.
// R4: Master compares returned echo with its sent counter to confirm reception.
// R5: Node address is the rotary switch value taken at power-up, not echoed.
// R6: Status byte 2 holds eight flags, bit 7 energized down to target reached.
// R7: Energized flag is 1 while motor is energized in servo-on.
// R8: Energized flag reads off during dynamic-brake deceleration.
// R9: With hold option set, energized stays off until commands are accepted.
// R10: Armable only when mains up, no alarm, and synchronized, all together.
// R11: Alarm flag is 1 whenever an alarm is present.
// R12: Warning flag is 1 whenever a warning is present.
// R13: Warning flag latches or follows live condition per latch setup.
// R14: Torque clamp flag is 1 while the torque command is limited.
// R15: In torque mode, clamp condition comes from the torque output setup.
// R16: Home found sets on homing done, holds, clears on homing command.
// R17: Header and status bytes refresh with current values every cycle.
module servo_resp_framer
  import servo_resp_pkg::*;
(
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Command frame side
  input  wire logic              frame_tick,
  input  wire logic [ECHO_W-1:0] cmd_update_counter,
  input  wire logic [NODE_W-1:0] rotary_address_switch,
  // Drive conditions
  input  wire logic              motor_energized,
  input  wire logic              dyn_brake_decel,
  input  wire logic              cmd_accept_ready,
  input  wire logic              main_power_ok,
  input  wire logic              alarm_active,
  input  wire logic              sync_ok,
  input  wire logic              warning_active,
  input  wire logic              torque_limit_active,
  input  wire logic              torque_ctrl_mode,
  input  wire logic              torque_limit_setup_cond,
  input  wire logic              homing_done,
  input  wire logic              homing_cmd,
  input  wire logic              motion_or_mains_loss_flag,
  input  wire logic              target_reached,
  // Response bytes
  output logic      [7:0]        resp_header,
  output logic      [7:0]        resp_status,
  output logic                   resp_valid,
  // Interrupt
  output logic                   irq
);

  typedef struct packed {
    logic              addr_taken;
    logic [NODE_W-1:0] addr;
    logic              hold_en;
    logic              warn_latch_en;
    logic              torque_out_sel;
    logic              warn;
    logic              home;
    logic              alarm_prev;
    logic              warn_prev;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_en;
    logic [APB_DW-1:0] prdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Address compare used by read and write decode
  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Whole map decode
  function automatic logic mapped(input logic [APB_AW-1:0] a);
    mapped = hit(a, OFF_CTRL) || hit(a, OFF_FLAGS) || hit(a, OFF_IRQ_STATUS) ||
             hit(a, OFF_IRQ_ENABLE) || hit(a, OFF_IRQ_CLEAR) || hit(a, OFF_WARN_CLEAR);
  endfunction : mapped

  logic       access;
  logic       wr_en;
  logic       rd_setup;
  logic       warn_clr;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_ev;
  logic       energized;
  logic       armable;
  logic       warn_flag;
  logic       clamp_flag;
  logic [7:0] flags;
  logic [7:0] hdr_live;

  // Bus phases; zero wait states
  assign access   = psel && penable;
  assign wr_en    = access && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign warn_clr = wr_en && hit(paddr, OFF_WARN_CLEAR) && pwdata[WCLR_BIT];
  assign irq_clr  = (wr_en && hit(paddr, OFF_IRQ_CLEAR)) ? pwdata[IRQ_W-1:0] : '0;

  // R7: energized while servo-on
  // R8: dynamic braking reads as off
  // R9: optional hold until commands accepted
  assign energized = motor_energized && !dyn_brake_decel && !(s_q.hold_en && !cmd_accept_ready);

  // R10: all three conditions together
  assign armable = main_power_ok && !alarm_active && sync_ok;

  // R12: live warning always shown
  // R13: latched copy adds when enabled
  assign warn_flag = warning_active || s_q.warn;

  // R14: clamp while limited
  // R15: torque mode uses setup condition
  assign clamp_flag = (torque_ctrl_mode && s_q.torque_out_sel) ? torque_limit_setup_cond
                                                               : torque_limit_active;

  // R6: status byte layout
  always_comb begin
    flags                  = '0;
    flags[ST_ENERGIZED]    = energized;
    flags[ST_ARMABLE]      = armable;
    flags[ST_ALARM]        = alarm_active;  // R11: live alarm
    flags[ST_WARNING]      = warn_flag;
    flags[ST_TORQUE_CLAMP] = clamp_flag;
    flags[ST_HOME_FOUND]   = s_q.home;
    flags[ST_MOTION_MAINS] = motion_or_mains_loss_flag;
    flags[ST_TARGET_REACH] = target_reached;
  end

  // Header image for register readback
  always_comb begin
    hdr_live                         = '0;
    hdr_live[HDR_MARKER_BIT]         = RESP_MARKER;
    hdr_live[ECHO_LSB +: ECHO_W]     = cmd_update_counter;
    hdr_live[NODE_W-1:0]             = s_q.addr;
  end

  // Interrupt events
  always_comb begin
    irq_ev            = '0;
    irq_ev[IRQ_ALARM] = alarm_active && !s_q.alarm_prev;
    irq_ev[IRQ_WARN]  = warn_flag && !s_q.warn_prev;
    irq_ev[IRQ_HOME]  = homing_done;
    irq_ev[IRQ_FRAME] = frame_tick;
  end

  // Next state
  always_comb begin
    s_d            = s_q;
    s_d.alarm_prev = alarm_active;
    s_d.warn_prev  = warn_flag;
    // R5: switch captured once after reset release
    if (!s_q.addr_taken) begin
      s_d.addr       = rotary_address_switch;
      s_d.addr_taken = 1'b1;
    end
    // R13: latch holds until cleared, set wins
    s_d.warn = s_q.warn_latch_en && (warning_active || (s_q.warn && !warn_clr));
    // R16: sticky home, set wins over clear
    s_d.home = homing_done || (s_q.home && !homing_cmd);
    // Sticky interrupt status, set wins
    s_d.irq_st = irq_ev | (s_q.irq_st & ~irq_clr);
    // Register writes
    if (wr_en && hit(paddr, OFF_CTRL)) begin
      s_d.hold_en        = pwdata[CTRL_HOLD_BIT];
      s_d.warn_latch_en  = pwdata[CTRL_WLATCH_BIT];
      s_d.torque_out_sel = pwdata[CTRL_TQSEL_BIT];
    end
    if (wr_en && hit(paddr, OFF_IRQ_ENABLE)) begin
      s_d.irq_en = pwdata[IRQ_W-1:0];
    end
    // Read data captured in setup phase
    if (rd_setup) begin
      s_d.prdata = '0;
      if (hit(paddr, OFF_CTRL)) begin
        s_d.prdata[CTRL_HOLD_BIT]   = s_q.hold_en;
        s_d.prdata[CTRL_WLATCH_BIT] = s_q.warn_latch_en;
        s_d.prdata[CTRL_TQSEL_BIT]  = s_q.torque_out_sel;
      end else if (hit(paddr, OFF_FLAGS)) begin
        s_d.prdata[FLG_STATUS_LSB +: 8]      = flags;
        s_d.prdata[FLG_HEADER_LSB +: 8]      = hdr_live;
        s_d.prdata[FLG_NODE_LSB +: NODE_W]   = s_q.addr;
      end else if (hit(paddr, OFF_IRQ_STATUS)) begin
        s_d.prdata[IRQ_W-1:0] = s_q.irq_st;
      end else if (hit(paddr, OFF_IRQ_ENABLE)) begin
        s_d.prdata[IRQ_W-1:0] = s_q.irq_en;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{addr_taken: 1'b0, addr: '0, hold_en: 1'b0, warn_latch_en: 1'b0,
               torque_out_sel: 1'b0, warn: 1'b0, home: 1'b0, alarm_prev: 1'b0,
               warn_prev: 1'b0, irq_st: '0, irq_en: '0, prdata: RDATA_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers
  assign prdata  = s_q.prdata;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped(paddr);
  assign irq     = |(s_q.irq_st & s_q.irq_en);

  // R1: frame byte builder
  resp_byte_builder u_builder (
    .pclk               (pclk),
    .presetn            (presetn),
    .frame_tick         (frame_tick),
    .update_count       (cmd_update_counter),
    .node_address_field (s_q.addr),
    .status_flags       (flags),
    .resp_header        (resp_header),
    .resp_status        (resp_status),
    .resp_valid         (resp_valid)
  );

  // Checks on the response bytes and the internal flag and address state
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MARKER: assert property (resp_valid |-> resp_header[HDR_MARKER_BIT]) // R2
    else $error("response marker not set");

  AST_ECHO: assert property (frame_tick |=> resp_header[ECHO_LSB +: ECHO_W] == $past(cmd_update_counter)) // R3
    else $error("counter echo mismatch");

  AST_NODE: assert property (resp_valid |-> resp_header[NODE_W-1:0] == s_q.addr && s_q.addr_taken) // R5
    else $error("node address not the strapped value");

  AST_NODE_STABLE: assert property (s_q.addr_taken |=> $stable(s_q.addr)) // R5
    else $error("node address changed after capture");

  AST_REFRESH: assert property (frame_tick |=> resp_valid ##1 (!resp_valid || $past(frame_tick))) // R17
    else $error("frame not refreshed");

  AST_DYNBRAKE: assert property (frame_tick && dyn_brake_decel |=> !resp_status[ST_ENERGIZED]) // R8
    else $error("energized shown during braking");

  AST_HOLD: assert property (frame_tick && s_q.hold_en && !cmd_accept_ready |=> !resp_status[ST_ENERGIZED]) // R9
    else $error("energized shown before commands accepted");

  AST_ENERGIZED: assert property (frame_tick && motor_energized && !dyn_brake_decel && !s_q.hold_en
                                  |=> resp_status[ST_ENERGIZED]) // R7
    else $error("energized flag missing");

  AST_ARMABLE: assert property (frame_tick |=> resp_status[ST_ARMABLE] ==
                                $past(main_power_ok && !alarm_active && sync_ok)) // R10
    else $error("armable flag wrong");

  AST_ALARM: assert property (frame_tick |=> resp_status[ST_ALARM] == $past(alarm_active)) // R11
    else $error("alarm flag wrong");

  AST_WARN_LATCH: assert property (s_q.warn_latch_en && warning_active && !$fell(s_q.warn_latch_en)
                                   ##1 s_q.warn_latch_en && !warn_clr [*2] |-> warn_flag) // R13
    else $error("latched warning lost");

  AST_WARN_LIVE: assert property (warning_active |-> warn_flag) // R12
    else $error("live warning not shown");

  AST_CLAMP: assert property (!torque_ctrl_mode && torque_limit_active |-> flags[ST_TORQUE_CLAMP]) // R14
    else $error("torque clamp flag missing");

  AST_CLAMP_TQ: assert property (torque_ctrl_mode && s_q.torque_out_sel
                                 |-> flags[ST_TORQUE_CLAMP] == torque_limit_setup_cond) // R15
    else $error("torque mode clamp source wrong");

  AST_HOME: assert property (homing_done |=> s_q.home) // R16
    else $error("home found not set");

  AST_HOME_HOLD: assert property (s_q.home && !homing_cmd |=> s_q.home) // R16
    else $error("home found not held");

  AST_HOME_CLR: assert property (homing_cmd && !homing_done |=> !s_q.home) // R16
    else $error("home found not cleared by homing command");

endmodule : servo_resp_framer

//--- tb/cmd_master_model.sv
`timescale 1ns/1ps
module cmd_master_model
  import servo_resp_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Frame request from bench
  input  wire logic              go,
  // Command side
  output logic                   frame_tick,
  output logic      [ECHO_W-1:0] cmd_update_counter,
  // Response side
  input  wire logic              resp_valid,
  input  wire logic [7:0]        resp_header,
  output logic                   echo_bad
);
  logic [ECHO_W-1:0] sent_q;

  // Counter only valid with the tick, scrambled otherwise
  assign cmd_update_counter = frame_tick ? sent_q : ~sent_q;

  // Issue frames, compare returned echo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_tick <= 1'h0;
      sent_q     <= '0;
      echo_bad   <= 1'h0;
    end else begin
      frame_tick <= go;
      if (go) begin
        sent_q <= sent_q + 1'h1;
      end
      if (resp_valid && resp_header[ECHO_LSB +: ECHO_W] != sent_q) begin
        echo_bad <= 1'h1;
      end
    end
  end
endmodule : cmd_master_model

//--- tb/servo_response_header_status_bench.sv
`timescale 1ns/1ps
module servo_response_header_status_bench
  import servo_resp_pkg::*;
;
  // Bench signals
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              go;
  logic              tick;
  logic [ECHO_W-1:0] cnt;
  logic [NODE_W-1:0] sw;
  logic [13:0]       c;
  logic [7:0]        hdr;
  logic [7:0]        st;
  logic              rv;
  logic              irq;
  logic              echo_bad;
  logic [31:0]       r;
  logic              e;
  logic [ECHO_W-1:0] hc;
  int                n_fail;
  int                n_tests;

  // Clock
  always #5 pclk = ~pclk;

  servo_resp_framer dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_tick(tick), .cmd_update_counter(cnt), .rotary_address_switch(sw),
    .motor_energized(c[13]), .dyn_brake_decel(c[12]), .cmd_accept_ready(c[11]),
    .main_power_ok(c[10]), .alarm_active(c[9]), .sync_ok(c[8]), .warning_active(c[7]),
    .torque_limit_active(c[6]), .torque_ctrl_mode(c[5]), .torque_limit_setup_cond(c[4]),
    .homing_done(c[3]), .homing_cmd(c[2]), .motion_or_mains_loss_flag(c[1]),
    .target_reached(c[0]), .resp_header(hdr), .resp_status(st), .resp_valid(rv), .irq(irq));

  cmd_master_model master (
    .pclk(pclk), .presetn(presetn), .go(go), .frame_tick(tick), .cmd_update_counter(cnt),
    .resp_valid(rv), .resp_header(hdr), .echo_bad(echo_bad));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, result in r and e
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Set control and conditions, send a frame, check both bytes
  task automatic frame(input logic [2:0] ctl, input logic [13:0] cv, input logic [7:0] exp);
    apb(OFF_CTRL, 1'h1, {29'h0, ctl});
    @(posedge pclk);
    c  <= cv;
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    hc = hc + 1'h1;
    repeat (4) begin
      @(negedge pclk);
      if (rv === 1'h1) break;
    end
    chk(rv, 32'h1);
    chk(hdr, {RESP_MARKER, hc, 5'h13});
    chk(st, exp);
  endtask : frame

  // Print counts and verdict
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    pclk    = 1'h0;
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = '0;
    pwdata  = '0;
    go      = 1'h0;
    c       = '0;
    sw      = 5'h13;
    hc      = '0;
    n_fail  = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(OFF_CTRL, 1'h0, 32'h0);
    chk(r, 32'h0);
    apb(12'h100, 1'h0, 32'h0);
    chk(e, 32'h1);
    chk(r, 32'h0);
    apb(OFF_CTRL, 1'h1, 32'h7);
    apb(OFF_CTRL, 1'h0, 32'h0);
    chk(r, 32'h7);
    apb(OFF_FLAGS, 1'h1, 32'hffff_ffff);
    apb(OFF_FLAGS, 1'h0, 32'h0);
    chk(r[20:16], 32'h13);
    $display("test registers done");
    sw <= 5'h04;
    // every echo value, switch moved after power-up
    for (int i = 0; i < 4; i++) frame(3'h0, 14'h0, 8'h00);
    $display("test header done");
    frame(3'h0, 14'h2d00, 8'hc0);
    frame(3'h0, 14'h3d00, 8'h40);
    frame(3'h1, 14'h2500, 8'h40);
    frame(3'h1, 14'h2d00, 8'hc0);
    frame(3'h0, 14'h0400, 8'h00);
    frame(3'h0, 14'h00c0, 8'h18);
    frame(3'h0, 14'h0000, 8'h00);
    frame(3'h2, 14'h0080, 8'h10);
    frame(3'h2, 14'h0000, 8'h10);
    apb(OFF_WARN_CLEAR, 1'h1, 32'h1);
    frame(3'h2, 14'h0000, 8'h00);
    frame(3'h4, 14'h0030, 8'h08);
    frame(3'h4, 14'h0060, 8'h00);
    frame(3'h0, 14'h0060, 8'h08);
    frame(3'h0, 14'h0008, 8'h04);
    frame(3'h0, 14'h0000, 8'h04);
    frame(3'h0, 14'h0004, 8'h00);
    frame(3'h0, 14'h0003, 8'h03);
    $display("test status done");
    apb(OFF_IRQ_ENABLE, 1'h1, 32'h1);
    apb(OFF_IRQ_ENABLE, 1'h0, 32'h0);
    chk(r, 32'h1);
    apb(OFF_IRQ_CLEAR, 1'h1, 32'hf);
    frame(3'h0, 14'h0700, 8'h20);
    @(negedge pclk);
    chk(irq, 32'h1);
    apb(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk(r & 32'h9, 32'h9);
    apb(OFF_IRQ_CLEAR, 1'h1, 32'hf);
    apb(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk(r, 32'h0);
    frame(3'h0, 14'h0700, 8'h20);
    apb(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk(r, 32'h8);
    @(negedge pclk);
    chk(irq, 32'h0);
    frame(3'h0, 14'h0088, 8'h14);
    apb(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk(r, 32'he);
    chk(echo_bad, 32'h0);
    $display("test interrupt done");
    conclude();
  end
endmodule : servo_response_header_status_bench
